// ### pkg/fcc_consts.svh
// Purpose: Constants of the filter configuration and conversion control block
// Assumes: Included by the design file and by the bench
// Notes: Definitions only
`ifndef FCC_CONSTS_SVH
`define FCC_CONSTS_SVH

// ----------------------------------------------------------------------------
// Parallel instruction codes
// ----------------------------------------------------------------------------
`define FCC_CMD_ABORT 16'h0000
`define FCC_CMD_RD_ID 16'h8802
`define FCC_CMD_STREAM 16'h8D21
`define FCC_CMD_LOAD 16'h1800
`define FCC_CMD_LOAD_MASKED 16'h1A00
`define FCC_CMD_ROM 16'h2000

// ----------------------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------------------
`define FCC_ST_BUSY 15
`define FCC_ST_READY 14
`define FCC_ST_REQ 13
`define FCC_ST_ID_ERR 12
`define FCC_ST_CRC_ERR 11
`define FCC_ST_DATA_ERR 10
`define FCC_ST_INSTR_HI 9
`define FCC_ST_INSTR_LO 1
`define FCC_ST_DONE 0

// ----------------------------------------------------------------------------
// Configuration file layout
// ----------------------------------------------------------------------------
`define FCC_BLK_LAST 6'd41
`define FCC_FILE_LAST 9'd503
`define FCC_FILE_ID 16'hA5C3
`define FCC_ROM_SEED 16'h5A5A
// Arbitrary identification value
`define FCC_DEV_ID 16'h1234

// ----------------------------------------------------------------------------
// Serial submodes and timing (half periods of the serial clock in clk cycles)
// ----------------------------------------------------------------------------
`define FCC_SUB_ROM 2'b00
`define FCC_SUB_DSP 2'b01
`define FCC_SCO_CFG_HALF 5'd16
`define FCC_SCO_FAST_HALF 5'd1
`define FCC_SCO_SLOW_HALF 5'd2
`define FCC_WORD_BITS 5'd16
`define FCC_BOOT_WAIT 2'd3

`endif

// ### pkg/fcc_pkg.sv
// Purpose: Types of the filter configuration and conversion control block
// Assumes: Nothing
// Notes: Constants live in fcc_consts.svh
package fcc_pkg;

  typedef logic [15:0] fcc_word_t;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_PLOAD = 3'b010,
    ST_ROM = 3'b011,
    ST_SLOAD = 3'b100,
    ST_READY = 3'b101,
    ST_CONV = 3'b110,
    ST_FAIL = 3'b111
  } fcc_state_e;

endpackage

// ### hdl/fcc_top.sv
// Purpose: Loads the postprocessor filter configuration and runs conversion output
// Assumes: clk_i is 40 MHz; master clock rate taken as clk_i/2
// Notes: Parallel host port is synchronous; serial pins are synchronised
//
// Notes on behaviour
// - After load instruction, interrupt raised each time next word is needed.
// - A data write clears a pending word-request interrupt.
// - Interrupt raised right after the last configuration word.
// - Unmasked load raises interrupt on bad file identifier or checksum.
// - A corrupt file is never committed to the postprocessor.
// - Masked load raises no error interrupt, takes all 504 words, then done.
// - ROM boot instruction loads the built-in default filter.
// - In streaming, interrupt and status bit 14 rise when a result waits.
// - Interrupt held until result or status read, then low until next result.
// - Streaming continues until the abort instruction.
// - Mode pin low is parallel; submode 00 ROM, 01 DSP, 1x EPROM.
// - Serial mode is master only; all bits move with our serial clock.
// - Edge pins pick active serial clock edge for conversion and DSP submode configuration.
// - DSP submode loads with the serial clock at master clock over 16.
// - DSP submode raises source enable once power-on reset ends.
// - Good serial load raises config done; start input then begins conversions.
// - Serial error drives error low, stays idle; reconfig pulse restarts load.
// - DSP submode reads whole file before reporting an error.
// - After loading, rate pin 0 gives master clock, 1 gives half of it.
// - DSP frame pulse precedes each word, captured over next 16 clocks.
// - EPROM submode drives source enable low and samples on rising edges.
// - EPROM load done raises source enable and config done; error holds in fail state.
// - Parallel instruction write or status read clears the interrupt.
// - Register select high picks status or instruction, low picks data.
`timescale 1ns/1ps
`include "fcc_consts.svh"

module fcc_top import fcc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Parallel host port
  input wire logic bus_addr_i,
  input wire logic [15:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [15:0] bus_rdata_o,
  output logic int_o,
  // Mode pins
  input wire logic serial_parallel_i,
  input wire logic serial_submode_bit0_i,
  input wire logic serial_submode_bit1_i,
  input wire logic conv_edge_select_i,
  input wire logic cfg_edge_select_i,
  input wire logic clock_rate_select_i,
  input wire logic reconfig_reset_n_i,
  input wire logic conv_start_i,
  // Serial link
  input wire logic frame_sync_in_i,
  input wire logic serial_data_in_i,
  output logic serial_clock_out_o,
  output logic serial_data_out_o,
  output logic frame_sync_out_o,
  output logic source_enable_o,
  output logic config_done_o,
  output logic error_n_o,
  // Postprocessor side
  input wire logic [15:0] conv_word_i,
  input wire logic conv_valid_i,
  input wire logic conv_overflow_i,
  output logic [15:0] cfg_word_o,
  output logic cfg_we_o,
  output logic cfg_commit_o
);

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [9:0] async_in;
  logic [9:0] sync_in;
  assign async_in = {serial_parallel_i, serial_submode_bit1_i, serial_submode_bit0_i,
                     conv_edge_select_i, cfg_edge_select_i, clock_rate_select_i,
                     reconfig_reset_n_i, conv_start_i, frame_sync_in_i, serial_data_in_i};

  genvar g;
  generate
    for (g = 0; g < 10; g++)
    begin : g_sync
      logic meta;
      logic stable;
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          meta <= 1'b0;
          stable <= 1'b0;
        end
        else
        begin
          meta <= async_in[g];
          stable <= meta;
        end
      end
      assign sync_in[g] = stable;
    end
  endgenerate

  logic sp_s, conv_edge_select_s, cfg_edge_select_s, scr_s, rcf_n_s, start_s, fsi_s, sdi_s;
  logic [1:0] sub_s;
  assign sp_s = sync_in[9];
  assign sub_s = sync_in[8:7];
  assign conv_edge_select_s = sync_in[6];
  assign cfg_edge_select_s = sync_in[5];
  assign scr_s = sync_in[4];
  assign rcf_n_s = sync_in[3];
  assign start_s = sync_in[2];
  assign fsi_s = sync_in[1];
  assign sdi_s = sync_in[0];

  logic fsi_d, rcf_d;
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      fsi_d <= 1'b0;
      rcf_d <= 1'b0;
    end
    else
    begin
      fsi_d <= fsi_s;
      rcf_d <= rcf_n_s;
    end
  end

  logic fsi_rise, rcf_fall;
  assign fsi_rise = fsi_s & ~fsi_d;
  assign rcf_fall = rcf_d & ~rcf_n_s;

  // --------------------------------------------------------------------------
  // State and host decode
  // --------------------------------------------------------------------------
  fcc_state_e st;
  logic ser_mode, masked, int_req, data_req, cfg_ok, data_ready, data_err;
  logic [1:0] sub, boot_cnt;
  fcc_word_t instr, out_word;

  logic ins_wr, dat_wr, sta_rd, dat_rd;
  assign ins_wr = bus_wr_i & bus_addr_i & ~ser_mode;
  assign dat_wr = bus_wr_i & ~bus_addr_i & ~ser_mode;
  assign sta_rd = bus_rd_i & bus_addr_i & ~ser_mode;
  assign dat_rd = bus_rd_i & ~bus_addr_i & ~ser_mode;

  logic cmd_abort, cmd_load, cmd_rom, cmd_stream, cmd_rdid;
  assign cmd_abort = ins_wr && bus_wdata_i == `FCC_CMD_ABORT;
  assign cmd_load = ins_wr && st == ST_IDLE &&
                    (bus_wdata_i == `FCC_CMD_LOAD || bus_wdata_i == `FCC_CMD_LOAD_MASKED);
  assign cmd_rom = ins_wr && st == ST_IDLE && bus_wdata_i == `FCC_CMD_ROM;
  assign cmd_stream = ins_wr && st == ST_IDLE && cfg_ok && bus_wdata_i == `FCC_CMD_STREAM;
  assign cmd_rdid = ins_wr && st == ST_IDLE && bus_wdata_i == `FCC_CMD_RD_ID;

  // --------------------------------------------------------------------------
  // Serial clock generator
  // --------------------------------------------------------------------------
  logic serial_clock_out, sco_run, sco_cfg, sco_tog, sco_rise, sco_fall;
  logic [4:0] sco_cnt, sco_half;
  assign sco_run = ser_mode && (st == ST_SLOAD || st == ST_ROM || st == ST_READY || st == ST_CONV);
  assign sco_cfg = st == ST_SLOAD || st == ST_ROM;
  always_comb
  begin
    if (sco_cfg)
      sco_half = `FCC_SCO_CFG_HALF;
    else if (scr_s)
      sco_half = `FCC_SCO_SLOW_HALF;
    else
      sco_half = `FCC_SCO_FAST_HALF;
  end
  assign sco_tog = sco_run && (sco_cnt >= sco_half - 5'd1);
  assign sco_rise = sco_tog & ~serial_clock_out;
  assign sco_fall = sco_tog & serial_clock_out;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      serial_clock_out <= 1'b0;
      sco_cnt <= 5'd0;
    end
    else if (!sco_run)
    begin
      serial_clock_out <= 1'b0;
      sco_cnt <= 5'd0;
    end
    else if (sco_tog)
    begin
      serial_clock_out <= ~serial_clock_out;
      sco_cnt <= 5'd0;
    end
    else
      sco_cnt <= sco_cnt + 5'd1;
  end

  // --------------------------------------------------------------------------
  // Serial configuration receiver
  // --------------------------------------------------------------------------
  logic is_dsp, rx_edge, rx_act, rx_stb;
  logic [4:0] rx_cnt, rx_left;
  fcc_word_t rx_sh;
  assign is_dsp = sub == `FCC_SUB_DSP;
  assign rx_edge = is_dsp ? (cfg_edge_select_s ? sco_fall : sco_rise) : sco_rise;
  assign rx_act = is_dsp ? (rx_cnt != 5'd0) : 1'b1;
  assign rx_left = (rx_cnt == 5'd0) ? `FCC_WORD_BITS : rx_cnt;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_cnt <= 5'd0;
      rx_sh <= 16'h0000;
      rx_stb <= 1'b0;
    end
    else
    begin
      rx_stb <= 1'b0;
      if (st != ST_SLOAD)
        rx_cnt <= 5'd0;
      else if (is_dsp && rx_cnt == 5'd0 && fsi_rise)
        rx_cnt <= `FCC_WORD_BITS;
      else if (rx_edge && rx_act)
      begin
        rx_sh <= {rx_sh[14:0], sdi_s};
        rx_cnt <= rx_left - 5'd1;
        rx_stb <= rx_left == 5'd1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Loader: word counting and file checks
  // --------------------------------------------------------------------------
  logic [8:0] wcnt;
  logic [5:0] widx;
  fcc_word_t acc, ld_word, rom_word;
  logic id_err, crc_err, ld_clr, ld_stb, id_bad, crc_bad, ld_bad, ld_last, file_ok;

  assign rom_word = (widx == 6'd0) ? `FCC_FILE_ID :
                    (widx == `FCC_BLK_LAST) ? acc : (`FCC_ROM_SEED ^ {7'd0, wcnt});
  assign ld_clr = st == ST_BOOT || cmd_load || cmd_rom;
  assign ld_stb = (st == ST_PLOAD && dat_wr && data_req) || st == ST_ROM || (st == ST_SLOAD && rx_stb);
  assign ld_word = (st == ST_ROM) ? rom_word : (st == ST_SLOAD) ? rx_sh : bus_wdata_i;
  assign id_bad = ld_stb && widx == 6'd0 && ld_word != `FCC_FILE_ID;
  assign crc_bad = ld_stb && widx == `FCC_BLK_LAST && ld_word != acc;
  assign ld_bad = id_bad | crc_bad;
  assign ld_last = ld_stb && wcnt == `FCC_FILE_LAST;
  assign file_ok = !(id_err || crc_err || ld_bad);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wcnt <= 9'd0;
      widx <= 6'd0;
      acc <= 16'h0000;
      id_err <= 1'b0;
      crc_err <= 1'b0;
    end
    else if (ld_clr)
    begin
      wcnt <= 9'd0;
      widx <= 6'd0;
      acc <= 16'h0000;
      id_err <= 1'b0;
      crc_err <= 1'b0;
    end
    else if (ld_stb)
    begin
      wcnt <= wcnt + 9'd1;
      widx <= (widx == `FCC_BLK_LAST) ? 6'd0 : widx + 6'd1;
      acc <= (widx == `FCC_BLK_LAST) ? 16'h0000 : acc ^ ld_word;
      id_err <= id_err | id_bad;
      crc_err <= crc_err | crc_bad;
    end
  end

  // Words go to staging; only the commit pulse makes them live
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cfg_word_o <= 16'h0000;
      cfg_we_o <= 1'b0;
      cfg_commit_o <= 1'b0;
    end
    else
    begin
      cfg_we_o <= ld_stb;
      if (ld_stb)
        cfg_word_o <= ld_word;
      cfg_commit_o <= ld_last && file_ok;
    end
  end

  // --------------------------------------------------------------------------
  // Main sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st <= ST_BOOT;
      boot_cnt <= `FCC_BOOT_WAIT;
      ser_mode <= 1'b0;
      sub <= 2'b00;
      masked <= 1'b0;
      int_req <= 1'b0;
      data_req <= 1'b0;
      cfg_ok <= 1'b0;
    end
    else
    begin
      int_req <= 1'b0;
      if (ser_mode && rcf_fall)
      begin
        st <= ST_BOOT;
        boot_cnt <= `FCC_BOOT_WAIT;
        cfg_ok <= 1'b0;
      end
      else if (cmd_abort)
      begin
        st <= (st == ST_BOOT) ? ST_BOOT : ST_IDLE;
        data_req <= 1'b0;
      end
      else
      begin
        unique case (st)
          ST_BOOT:
          begin
            boot_cnt <= boot_cnt - 2'd1;
            if (boot_cnt == 2'd0)
            begin
              ser_mode <= sp_s;
              sub <= sub_s;
              if (!sp_s)
              begin
                st <= ST_IDLE;
                int_req <= 1'b1;
              end
              else if (sub_s == `FCC_SUB_ROM)
                st <= ST_ROM;
              else
                st <= ST_SLOAD;
            end
          end
          ST_IDLE:
          begin
            if (cmd_load)
            begin
              st <= ST_PLOAD;
              masked <= bus_wdata_i == `FCC_CMD_LOAD_MASKED;
              data_req <= 1'b1;
              int_req <= 1'b1;
              cfg_ok <= 1'b0;
            end
            else if (cmd_rom)
            begin
              st <= ST_ROM;
              cfg_ok <= 1'b0;
            end
            else if (cmd_stream)
              st <= ST_CONV;
          end
          ST_PLOAD:
          begin
            if (ld_last)
            begin
              st <= ST_IDLE;
              data_req <= 1'b0;
              int_req <= 1'b1;
              cfg_ok <= file_ok;
            end
            else if (ld_bad && !masked)
            begin
              st <= ST_IDLE;
              data_req <= 1'b0;
              int_req <= 1'b1;
            end
            else if (ld_stb)
              int_req <= 1'b1;
          end
          ST_ROM:
          begin
            if (ld_last)
            begin
              cfg_ok <= file_ok;
              st <= ser_mode ? (file_ok ? ST_READY : ST_FAIL) : ST_IDLE;
              int_req <= ~ser_mode;
            end
          end
          ST_SLOAD:
          begin
            if (ld_last)
            begin
              cfg_ok <= file_ok;
              st <= file_ok ? ST_READY : ST_FAIL;
            end
          end
          ST_READY:
          begin
            if (start_s)
              st <= ST_CONV;
          end
          ST_CONV:
          begin
            if (ser_mode && !start_s)
              st <= ST_READY;
          end
          ST_FAIL:
          begin
            st <= ST_FAIL;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial status pins
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      config_done_o <= 1'b0;
      error_n_o <= 1'b1;
      source_enable_o <= 1'b0;
    end
    else
    begin
      config_done_o <= ser_mode && (st == ST_READY || st == ST_CONV);
      error_n_o <= st != ST_FAIL;
      if (!ser_mode)
        source_enable_o <= 1'b0;
      else if (is_dsp)
        source_enable_o <= st == ST_SLOAD || st == ST_READY || st == ST_CONV;
      else
        source_enable_o <= st != ST_SLOAD;
    end
  end

  // --------------------------------------------------------------------------
  // Parallel interrupt and status
  // --------------------------------------------------------------------------
  logic par_conv, int_set, int_clr;
  assign par_conv = st == ST_CONV && !ser_mode && conv_valid_i;
  assign int_set = int_req | par_conv;
  assign int_clr = ins_wr | sta_rd | dat_rd | (dat_wr && st == ST_PLOAD);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      int_o <= 1'b0;
    else if (int_set)
      int_o <= 1'b1;
    else if (int_clr)
      int_o <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      data_ready <= 1'b0;
      data_err <= 1'b0;
      out_word <= 16'h0000;
    end
    else
    begin
      if (par_conv)
      begin
        data_ready <= 1'b1;
        data_err <= conv_overflow_i;
        out_word <= conv_word_i;
      end
      else if (dat_rd)
        data_ready <= 1'b0;
      else if (st != ST_CONV)
        data_ready <= 1'b0;
      if (cmd_rdid)
        out_word <= `FCC_DEV_ID;
      if (cmd_stream)
        data_err <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      instr <= 16'h0000;
    else if (ins_wr)
      instr <= bus_wdata_i;
  end

  fcc_word_t status;
  always_comb
  begin
    status = 16'h0000;
    status[`FCC_ST_BUSY] = st == ST_PLOAD || st == ST_ROM;
    status[`FCC_ST_READY] = data_ready;
    status[`FCC_ST_REQ] = data_req;
    status[`FCC_ST_ID_ERR] = id_err;
    status[`FCC_ST_CRC_ERR] = crc_err;
    status[`FCC_ST_DATA_ERR] = data_err;
    status[`FCC_ST_INSTR_HI:`FCC_ST_INSTR_LO] = {instr[15], instr[13:11], instr[6:4], instr[1:0]};
    status[`FCC_ST_DONE] = cfg_ok;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      bus_rdata_o <= 16'h0000;
    else if (sta_rd)
      bus_rdata_o <= status;
    else if (dat_rd)
      bus_rdata_o <= out_word;
    else
      bus_rdata_o <= 16'h0000;
  end

  // --------------------------------------------------------------------------
  // Serial conversion transmitter
  // --------------------------------------------------------------------------
  logic tx_pend, tx_edge, tx_load, ser_conv;
  logic [4:0] tx_bits;
  fcc_word_t tx_buf, tx_sh;
  assign ser_conv = ser_mode && st == ST_CONV;
  assign tx_edge = conv_edge_select_s ? sco_fall : sco_rise;
  assign tx_load = ser_conv && tx_edge && tx_bits == 5'd0 && tx_pend;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_pend <= 1'b0;
      tx_buf <= 16'h0000;
    end
    else if (!ser_conv)
      tx_pend <= 1'b0;
    else if (conv_valid_i)
    begin
      tx_pend <= 1'b1;
      tx_buf <= conv_word_i;
    end
    else if (tx_load)
      tx_pend <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      tx_bits <= 5'd0;
      tx_sh <= 16'h0000;
      serial_data_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
    end
    else if (!ser_conv)
    begin
      tx_bits <= 5'd0;
      serial_data_out_o <= 1'b0;
      frame_sync_out_o <= 1'b0;
    end
    else if (tx_edge)
    begin
      if (tx_load)
      begin
        frame_sync_out_o <= 1'b1;
        serial_data_out_o <= tx_buf[15];
        tx_sh <= {tx_buf[14:0], 1'b0};
        tx_bits <= `FCC_WORD_BITS - 5'd1;
      end
      else if (tx_bits != 5'd0)
      begin
        frame_sync_out_o <= 1'b0;
        serial_data_out_o <= tx_sh[15];
        tx_sh <= {tx_sh[14:0], 1'b0};
        tx_bits <= tx_bits - 5'd1;
      end
      else
        frame_sync_out_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      serial_clock_out_o <= 1'b0;
    else
      serial_clock_out_o <= serial_clock_out;
  end

endmodule

// ### tb/fcc_eprom_model.sv
// Purpose: Serial configuration memory on the far side of the link
// Assumes: Address counter restarts whenever it is enabled
// Notes: Released data line shows the inverse of its last bit
`timescale 1ns/1ps
module fcc_eprom_model (
  // Link
  input wire logic sco_i,
  input wire logic sen_i,
  output logic sd_o
);
  logic [12:0] addr = 13'h0;
  initial sd_o = 1'h0;
  always @(negedge sen_i)
    addr = 13'h0;
  always @(posedge sen_i)
    sd_o = ~sd_o;
  always @(negedge sco_i)
    if (!sen_i)
    begin
      sd_o = ^addr;
      addr = addr + 13'h1;
    end
endmodule

// ### tb/fcc_top_asserts.sv
// Purpose: Port checks of fcc_top
// Assumes: One clock domain
// Notes: Bound below the module
`timescale 1ns/1ps
module fcc_top_asserts (
  // Watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic bus_addr_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic conv_valid_i,
  input wire logic [15:0] bus_rdata_o,
  input wire logic int_o,
  input wire logic serial_clock_out_o,
  input wire logic frame_sync_out_o,
  input wire logic source_enable_o,
  input wire logic config_done_o,
  input wire logic error_n_o,
  input wire logic cfg_we_o,
  input wire logic cfg_commit_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence s_word_wr;
    bus_wr_i && !bus_addr_i && int_o ##1 cfg_we_o;
  endsequence
  sequence s_cfg_high;
    serial_clock_out_o [*8] ##8 serial_clock_out_o ##1 !serial_clock_out_o;
  endsequence
  a_rdata_idle: assert property (!bus_rd_i |=> bus_rdata_o == 16'h0000)
    else $error("read data outside its slot");
  a_word_rerequest: assert property (s_word_wr |-> !int_o ##1 int_o)
    else $error("word write did not clear and re-raise interrupt");
  a_status_clear: assert property (int_o && bus_rd_i && bus_addr_i && !conv_valid_i |=> !int_o)
    else $error("status read left interrupt high");
  a_commit_single: assert property (cfg_commit_o |=> !cfg_commit_o [*8])
    else $error("commit repeated");
  a_error_no_done: assert property (!error_n_o |-> !config_done_o)
    else $error("done with error");
  a_done_source: assert property (config_done_o |-> source_enable_o)
    else $error("done without source enable");
  a_frame_configured: assert property (frame_sync_out_o |-> config_done_o)
    else $error("frame output before configuration");
  a_load_clock: assert property ($rose(serial_clock_out_o) && !source_enable_o && error_n_o && !config_done_o
    |-> s_cfg_high)
    else $error("load clock half period wrong");
endmodule
bind fcc_top fcc_top_asserts u_fcc_top_asserts (.*);

// ### tb/fcc_top_bench.sv
// Purpose: Self-checking bench of fcc_top
// Assumes: Memory model feeds the serial data pin
// Notes: Serial file loads are too long to run whole
`timescale 1ns/1ps
`include "fcc_consts.svh"
module fcc_top_bench;
  logic [15:0] bus_wdata_i = 16'h0, conv_word_i = 16'h0, bus_rdata_o, cfg_word_o, q;
  logic clk_i = 1'h0, nrst_i = 1'h0, bus_addr_i = 1'h0, bus_wr_i = 1'h0, bus_rd_i = 1'h0;
  logic serial_parallel_i = 1'h0, serial_submode_bit0_i = 1'h0, serial_submode_bit1_i = 1'h0;
  logic conv_edge_select_i = 1'h0, cfg_edge_select_i = 1'h0, clock_rate_select_i = 1'h0;
  logic reconfig_reset_n_i = 1'h1, frame_sync_in_i = 1'h0, serial_data_in_i, conv_start_i;
  logic conv_valid_i = 1'h0, conv_overflow_i = 1'h0, int_o, serial_clock_out_o, serial_data_out_o;
  logic frame_sync_out_o, source_enable_o, config_done_o, error_n_o, cfg_we_o, cfg_commit_o;
  int miscompares = 0, tests_run = 0, commits = 0, c;
  assign conv_start_i = config_done_o;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i)
    if (cfg_commit_o === 1'h1)
      commits++;
  fcc_top u_fcc_top (.*);
  fcc_eprom_model u_fcc_eprom_model (.sco_i(serial_clock_out_o), .sen_i(source_enable_o), .sd_o(serial_data_in_i));
  // ----
  // Shared tasks
  // ----
  task automatic complete_run();
    $display("Counts: run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task automatic wr(input logic a, input logic [15:0] d);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_wdata_i <= d;
    bus_wr_i <= 1'h1;
    @(posedge clk_i);
    bus_wr_i <= 1'h0;
    #1;
  endtask
  task automatic rd(input logic a);
    @(posedge clk_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'h1;
    @(posedge clk_i);
    bus_rd_i <= 1'h0;
    #1 q = bus_rdata_o;
  endtask
  task automatic wait_for(ref logic s, input logic v, input int n);
    int k = 0;
    #1;
    while (s !== v && k < n)
    begin
      @(posedge clk_i);
      #1 k++;
    end
    if (s !== v)
    begin
      miscompares++;
      complete_run();
    end
  endtask
  task automatic rst(input logic sp, input logic [1:0] sm);
    @(posedge clk_i);
    nrst_i <= 1'h0;
    serial_parallel_i <= sp;
    {serial_submode_bit1_i, serial_submode_bit0_i} <= sm;
    repeat (5) @(posedge clk_i);
    nrst_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    #1;
  endtask
  task automatic load(input logic [15:0] cmd, input int bad, input int n);
    logic [15:0] x, w;
    c = commits;
    wr(1'h1, cmd);
    for (int i = 0; i < n; i++)
    begin
      wait_for(int_o, 1'h1, 40);
      if (i % 42 == 0)
        x = 16'h0;
      w = (i % 42 == 0) ? `FCC_FILE_ID : (i % 42 == 41) ? x ^ 16'(bad) : 16'(i);
      x ^= w;
      wr(1'h0, w);
      chk(int_o, 1'h0);
      chk(cfg_word_o, w);
    end
    wait_for(int_o, 1'h1, 40);
    rd(1'h1);
  endtask
  task automatic sample(input logic [15:0] w);
    @(posedge clk_i);
    conv_word_i <= w;
    conv_valid_i <= 1'h1;
    @(posedge clk_i);
    conv_valid_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_parallel();
    wait_for(int_o, 1'h1, 20);
    rd(1'h1);
    chk(int_o, 1'h0);
    rd(1'h1);
    c = q;
    wr(1'h1, 16'h4321);
    repeat (4) @(posedge clk_i);
    #1 chk(int_o, 1'h0);
    rd(1'h1);
    // Instruction bits of the status echo the last code written
    chk(q, 16'(c) | 16'h0012);
    wr(1'h1, `FCC_CMD_RD_ID);
    rd(1'h0);
    chk(q, `FCC_DEV_ID);
    load(`FCC_CMD_LOAD, 1, 42);
    chk(q[`FCC_ST_CRC_ERR], 1'h1);
    chk(16'(commits - c), 16'h0);
    load(`FCC_CMD_LOAD_MASKED, 1, 504);
    chk({q[`FCC_ST_CRC_ERR], q[`FCC_ST_DONE]}, 16'h2);
    chk(16'(commits - c), 16'h0);
    load(`FCC_CMD_LOAD, 0, 504);
    chk(q[`FCC_ST_DONE], 1'h1);
    chk(16'(commits - c), 16'h1);
    c = commits;
    wr(1'h1, `FCC_CMD_ROM);
    wait_for(int_o, 1'h1, 600);
    rd(1'h1);
    chk(q[`FCC_ST_DONE], 1'h1);
    chk(16'(commits - c), 16'h1);
    $display("load tests finished");
  endtask
  task automatic t_stream();
    wr(1'h1, `FCC_CMD_STREAM);
    for (int k = 0; k < 2; k++)
    begin
      sample(16'hA50F + 16'(k));
      chk(int_o, 1'h1);
      rd(1'h0);
      chk(q, 16'hA50F + 16'(k));
      chk(int_o, 1'h0);
    end
    sample(16'h1E2D);
    rd(1'h1);
    chk(q[`FCC_ST_READY], 1'h1);
    wr(1'h1, `FCC_CMD_ABORT);
    sample(16'h3C4B);
    chk(int_o, 1'h0);
    $display("stream test finished");
  endtask
  task automatic t_serial();
    int n = 0;
    rst(1'h1, 2'h0);
    wait_for(config_done_o, 1'h1, 600);
    repeat (8) @(posedge clk_i);
    conv_word_i <= 16'hC3A5;
    conv_valid_i <= 1'h1;
    @(posedge clk_i);
    conv_valid_i <= 1'h0;
    wait_for(frame_sync_out_o, 1'h1, 8);
    for (int b = 0; b < 16; b++)
    begin
      q = {q[14:0], serial_data_out_o};
      repeat (2) @(posedge clk_i);
      #1;
    end
    chk(q, 16'hC3A5);
    rst(1'h1, 2'h1);
    chk(source_enable_o, 1'h1);
    @(posedge clk_i);
    frame_sync_in_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    frame_sync_in_i <= 1'h0;
    wait_for(cfg_we_o, 1'h1, 700);
    chk(cfg_word_o, {16{serial_data_in_i}});
    rst(1'h1, 2'h2);
    chk(source_enable_o, 1'h0);
    wait_for(serial_clock_out_o, 1'h0, 100);
    wait_for(serial_clock_out_o, 1'h1, 100);
    while (serial_clock_out_o === 1'h1 && n < 40)
    begin
      @(posedge clk_i);
      #1 n++;
    end
    chk(16'(n), 16'h10);
    @(posedge clk_i);
    reconfig_reset_n_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    reconfig_reset_n_i <= 1'h1;
    repeat (12) @(posedge clk_i);
    #1 chk({source_enable_o, config_done_o, error_n_o}, 16'h1);
    $display("serial test finished");
  endtask
  initial
  begin
    rst(1'h0, 2'h0);
    t_parallel();
    t_stream();
    t_serial();
    complete_run();
  end
endmodule
